/* lpd_cfg.svh */
// Offsets, field positions, reset values and timing counts of the LED PWM configuration block
`ifndef LPD_CFG_SVH
`define LPD_CFG_SVH

// Register offsets
`define LPD_ADDR_UPD543 8'h1A
`define LPD_ADDR_GRPA 8'h1B
`define LPD_ADDR_GRPB 8'h1C
`define LPD_ADDR_LED0 8'h1D

// Field positions
`define LPD_UPD5_LSB 8
`define LPD_UPD4_LSB 4
`define LPD_UPD3_LSB 0
`define LPD_UPD2_LSB 6
`define LPD_UPD1_LSB 3
`define LPD_UPD0_LSB 0
`define LPD_FADE_BIT 12
`define LPD_UPD543_MASK 13'h0777

// Reset values and codes
`define LPD_REG_RESET 13'h0000
`define LPD_DUTY_RESET 12'h000
`define LPD_DUTY_FULL 12'hFFF
`define LPD_UPD_MAX_CODE 3'h5

// Timing counts
`define LPD_PERIOD_CYCLES 8192
`define LPD_FADE_SHIFT 3

`endif

/* lpd_pkg.sv */
// Types shared by the LED PWM configuration block
package lpd_pkg;
  typedef logic [12:0] lpd_reg_t;
  typedef logic [11:0] lpd_duty_t;
  typedef logic [2:0] lpd_ivl_t;
endpackage

/* lpd_tick_if.sv */
// PWM period timing shared from the period counter to every channel
`timescale 1ns/100ps
interface lpd_tick_if;
  logic period_end;
  logic [11:0] phase;
  modport src(output period_end, phase);
  modport snk(input period_end, phase);
endinterface

/* lpd_led_chan.sv */
// One LED channel: update interval, fade toward target and PWM compare
`timescale 1ns/100ps
`include "lpd_cfg.svh"
module lpd_led_chan (
  input wire logic clk,
  input wire logic reset,
  lpd_tick_if.snk tick,
  input wire lpd_pkg::lpd_ivl_t ivl_code,
  input wire lpd_pkg::lpd_duty_t target,
  input wire logic fade_en,
  output lpd_pkg::lpd_duty_t duty_now,
  output logic pwm_out
);
  import lpd_pkg::*;

  // ----------------------------------------
  // Update interval
  // ----------------------------------------
  logic [4:0] ivl_cnt_reg;
  wire capped = ivl_code >= `LPD_UPD_MAX_CODE; // [R2]
  wire [4:0] ivl_mask = capped ? 5'h1F : (5'h01 << ivl_code) - 5'h01; // [R1]
  wire update_due = tick.period_end && ((ivl_cnt_reg & ivl_mask) == ivl_mask); // [R14]

  // ----------------------------------------
  // Fade step
  // ----------------------------------------
  lpd_duty_t duty_reg, duty_next;
  wire up = target > duty_reg;
  wire [11:0] gap = up ? target - duty_reg : duty_reg - target;
  wire [11:0] gap_sh = gap >> `LPD_FADE_SHIFT;
  wire [11:0] step = (gap_sh == 12'h000) ? 12'h001 : gap_sh;
  wire [11:0] faded = up ? duty_reg + step : duty_reg - step;
  // Proportional steps give an exponential approach, even on a log scale
  assign duty_next = !update_due ? duty_reg :
                     (fade_en && gap != 12'h000) ? faded : target; // [R13]
  wire pwm_next = (duty_reg == `LPD_DUTY_FULL) || (tick.phase < duty_reg); // [R5]

  // Interval counter, active duty and output flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ivl_cnt_reg <= 5'h00;
      duty_reg <= `LPD_DUTY_RESET;
      pwm_out <= 1'b0;
    end else begin
      if (tick.period_end) ivl_cnt_reg <= ivl_cnt_reg + 5'h01;
      duty_reg <= duty_next;
      pwm_out <= pwm_next;
    end
  end
  assign duty_now = duty_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  hold_between_a: assert property (!update_due |=> duty_now == $past(duty_now)) // [R14]
    else $error("duty changed off an update boundary");
  direct_load_a: assert property (update_due && !fade_en |=> duty_now == $past(target)) // [R13]
    else $error("direct update did not load target");
  fade_step_a: assert property (update_due && fade_en && gap > 12'h010 |=> duty_now != $past(target)) // [R13]
    else $error("fade jumped straight to target");
  off_dark_a: assert property (duty_now == 12'h000 && !update_due |=> !pwm_out) // [R5]
    else $error("zero duty drove the LED on");
  full_on_a: assert property (duty_now == `LPD_DUTY_FULL && !update_due |=> pwm_out) // [R5]
    else $error("full duty let the LED off");
  cap_code_a: assert property (update_due && capped |-> ivl_cnt_reg == 5'h1F) // [R2]
    else $error("capped code updated early");
  code_one_a: assert property (update_due && ivl_code == 3'h1 |-> ivl_cnt_reg[0]) // [R1]
    else $error("two-period interval updated early");

  fade_seen_c: cover property (update_due && fade_en && gap > 12'h010);
  capped_seen_c: cover property (update_due && ivl_code == 3'h7);
endmodule // lpd_led_chan

/* lpd_led_pwm_cfg.sv */
// Six-channel LED PWM dimmer configuration: update intervals, group broadcast and LED0 duty
// Contract
// R1 - Interval codes 0 to 5 apply new duty every 1,2,4,8,16,32 periods.
// R2 - Interval codes 6 and 7 act like code 5, every 32 periods.
// R3 - A PWM period is 8192 clocks by default, shortened by a period select.
// R4 - Interval register: LED5 bits 10:8, LED4 bits 6:4, LED3 bits 2:0.
// R5 - Duty is linear: zero off, one is 1/4095, all ones fully on; at the default period the code lights a duty of one for 1/4096 of it.
// R6 - Writing group A duty copies it into every LED in group A.
// R7 - Writing group B duty copies it to group B; others keep their duty.
// R8 - One group write sets many LEDs; an LED may sit in both groups.
// R9 - Group A bit 12 is a fade enable copied with the duty.
// R10 - Group B bit 12 is a fade enable copied with the duty.
// R11 - LED0 register holds fade in bit 12, duty in 11:0, read and write.
// R12 - Registers reset to fade off, duty zero, interval code zero.
// R13 - Fade on moves gradually to the new duty; fade off switches directly.
// R14 - New duty takes effect only on a matching period boundary.
`timescale 1ns/100ps
`include "lpd_cfg.svh"
module lpd_led_pwm_cfg #(
  parameter int PERIOD_CYCLES = `LPD_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire lpd_pkg::lpd_reg_t reg_wdata,
  input wire logic [5:0] group_a_membership,
  input wire logic [5:0] group_b_membership,
  input wire logic [1:0] period_sel,
  input wire logic [8:0] led210_update_interval,
  output lpd_pkg::lpd_reg_t reg_rdata,
  output wire logic [5:0] led_pwm
);
  import lpd_pkg::*;

  localparam int NCH = 6;
  localparam int W = $clog2(PERIOD_CYCLES);

  // All inputs come from the serial register logic on this clock, so none is synchronised

  // ----------------------------------------
  // PWM period counter
  // ----------------------------------------
  lpd_tick_if tick ();
  logic [W-1:0] cnt_reg;
  wire [W-1:0] last_cnt = W'(PERIOD_CYCLES - 1) >> period_sel; // [R3]
  wire period_wrap = cnt_reg >= last_cnt;
  wire [W-1:0] cnt_next = period_wrap ? '0 : cnt_reg + 1'b1;
  // Scale the count to a 12-bit phase whatever the period length
  wire [W+11:0] scaled = {cnt_reg, 12'h000} << period_sel;
  wire [11:0] phase_next = scaled[W+11:W];

  // Period counter and shared tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      tick.period_end <= 1'b0;
      tick.phase <= 12'h000;
    end else begin
      cnt_reg <= cnt_next;
      tick.period_end <= period_wrap;
      tick.phase <= phase_next;
    end
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire wr_upd = reg_wr && reg_addr == `LPD_ADDR_UPD543;
  wire wr_a = reg_wr && reg_addr == `LPD_ADDR_GRPA;
  wire wr_b = reg_wr && reg_addr == `LPD_ADDR_GRPB;
  wire wr_l0 = reg_wr && reg_addr == `LPD_ADDR_LED0;

  lpd_reg_t upd543_reg, grpa_reg, grpb_reg;
  lpd_reg_t led_reg [NCH];
  lpd_reg_t led_next [NCH];

  // Per-LED duty and fade: group copy for members, LED0 direct write
  for (genvar i = 0; i < NCH; i++) begin : g_led
    wire hit_a = wr_a && group_a_membership[i]; // [R6] [R8]
    wire hit_b = wr_b && group_b_membership[i]; // [R7] [R8]
    wire hit_0 = (i == 0) && wr_l0; // [R11]
    assign led_next[i] = (hit_a || hit_b || hit_0) ? reg_wdata : led_reg[i]; // [R9] [R10]
  end

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      upd543_reg <= `LPD_REG_RESET; // [R12]
      grpa_reg <= `LPD_REG_RESET;
      grpb_reg <= `LPD_REG_RESET;
      for (int i = 0; i < NCH; i++) led_reg[i] <= `LPD_REG_RESET;
    end else begin
      if (wr_upd) upd543_reg <= reg_wdata & `LPD_UPD543_MASK; // [R4]
      if (wr_a) grpa_reg <= reg_wdata;
      if (wr_b) grpb_reg <= reg_wdata;
      for (int i = 0; i < NCH; i++) led_reg[i] <= led_next[i];
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  wire lpd_reg_t rd_mux = (reg_addr == `LPD_ADDR_UPD543) ? upd543_reg :
                          (reg_addr == `LPD_ADDR_GRPA) ? grpa_reg :
                          (reg_addr == `LPD_ADDR_GRPB) ? grpb_reg :
                          (reg_addr == `LPD_ADDR_LED0) ? led_reg[0] : `LPD_REG_RESET; // [R11]

  // Read data stands until the next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) reg_rdata <= `LPD_REG_RESET;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  lpd_ivl_t ivl [NCH];
  // Interval codes; LEDs 0 to 2 come from their own register outside this block
  assign ivl[0] = led210_update_interval[`LPD_UPD0_LSB +: 3];
  assign ivl[1] = led210_update_interval[`LPD_UPD1_LSB +: 3];
  assign ivl[2] = led210_update_interval[`LPD_UPD2_LSB +: 3];
  assign ivl[3] = upd543_reg[`LPD_UPD3_LSB +: 3]; // [R4]
  assign ivl[4] = upd543_reg[`LPD_UPD4_LSB +: 3];
  assign ivl[5] = upd543_reg[`LPD_UPD5_LSB +: 3];

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    lpd_led_chan u_chan (
      .clk(clk),
      .reset(reset),
      .tick(tick.snk),
      .ivl_code(ivl[i]),
      .target(led_reg[i][11:0]),
      .fade_en(led_reg[i][`LPD_FADE_BIT]),
      .duty_now(),
      .pwm_out(led_pwm[i])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  grp_a_copy_a: assert property (wr_a && group_a_membership[5] |=> led_reg[5][11:0] == $past(reg_wdata[11:0])) // [R6]
    else $error("group A duty not copied to member");
  grp_b_keep_a: assert property (wr_b && !group_b_membership[2] |=> led_reg[2] == $past(led_reg[2])) // [R7]
    else $error("group B write changed a non-member");
  grp_b_copy_a: assert property (wr_b && group_b_membership[1] |=> led_reg[1][11:0] == $past(reg_wdata[11:0])) // [R7]
    else $error("group B duty not copied to member");
  fade_a_copy_a: assert property (wr_a && group_a_membership[0] |=> led_reg[0][12] == $past(reg_wdata[12])) // [R9]
    else $error("group A fade not copied");
  fade_b_copy_a: assert property (wr_b && group_b_membership[3] |=> led_reg[3][12] == $past(reg_wdata[12])) // [R10]
    else $error("group B fade not copied");
  led0_read_a: assert property (wr_l0 ##1 (reg_rd && reg_addr == `LPD_ADDR_LED0) |=> reg_rdata == $past(reg_wdata, 2)) // [R11]
    else $error("LED0 readback differs from write");
  period_len_a: assert property (period_wrap && period_sel == 2'h0 |-> cnt_reg == W'(PERIOD_CYCLES - 1)) // [R3]
    else $error("period length wrong at default select");
  upd_unused_a: assert property (wr_upd |=> (upd543_reg & ~`LPD_UPD543_MASK) == 13'h0000) // [R4]
    else $error("unused interval bits set");

  both_groups_c: cover property (wr_a && group_a_membership[4] ##[1:20] wr_b && group_b_membership[4]);
  led0_write_c: cover property (wr_l0 && reg_wdata[12]);
  short_period_c: cover property (period_wrap && period_sel == 2'h3);
endmodule // lpd_led_pwm_cfg

/* tb_top.sv */
// Register-level testbench of the LED PWM configuration block
`timescale 1ns/100ps
module tb_top;
  import lpd_pkg::*;
  localparam int PER = 64;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  lpd_reg_t reg_wdata = 13'h0000;
  logic [5:0] group_a_membership = 6'h00;
  logic [5:0] group_b_membership = 6'h00;
  logic [5:0] led_pwm;
  lpd_reg_t reg_rdata;
  lpd_reg_t rd_val;
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic acc_or;
  logic acc_and;

  // Clock at 100 MHz
  always #5 clk = ~clk;

  lpd_led_pwm_cfg #(.PERIOD_CYCLES(PER)) DUT (
    .clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .group_a_membership(group_a_membership),
    .group_b_membership(group_b_membership), .period_sel(2'h0),
    .led210_update_interval(9'h000), .reg_rdata(reg_rdata), .led_pwm(led_pwm)
  );

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input lpd_reg_t seen, input lpd_reg_t exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input lpd_reg_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data settles one cycle after the strobe
  task automatic rd(input logic [7:0] a, output lpd_reg_t d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input lpd_reg_t exp);
    lpd_reg_t d;
    rd(a, d);
    check(d, exp);
  endtask

  // Cycles until an LED lights, bounded
  task automatic wait_lit(input int idx, output int cnt);
    cnt = 0;
    while (led_pwm[idx] !== 1'b1 && cnt < 40 * PER) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= 40 * PER) begin
      check(13'h0000, 13'h0001);
      tally_and_finish();
    end
  endtask

  // Sample one LED over two periods
  task automatic sample(input int idx);
    acc_or = 1'b0;
    acc_and = 1'b1;
    repeat (2 * PER) begin
      @(posedge clk);
      acc_or = acc_or | led_pwm[idx];
      acc_and = acc_and & led_pwm[idx];
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    for (int a = 8'h1A; a <= 8'h1D; a++) begin
      rd_chk(a[7:0], 13'h0000);
    end
    wr(8'h30, 13'h1FFF);
    rd_chk(8'h30, 13'h0000);
    // Interval fields only, gaps read zero
    wr(8'h1A, 13'h1FFF);
    rd_chk(8'h1A, 13'h0777);
    wr(8'h1A, 13'h0000);
    // LED0 fade and duty
    wr(8'h1D, 13'h1ABC);
    rd_chk(8'h1D, 13'h1ABC);
    // Group A broadcast reaches LED0 as a member
    group_a_membership <= 6'b001101;
    wr(8'h1B, 13'h10AA);
    rd_chk(8'h1D, 13'h10AA);
    rd_chk(8'h1B, 13'h10AA);
    // Group B broadcast, LED0 in both groups
    group_b_membership <= 6'b000011;
    wr(8'h1C, 13'h0555);
    rd_chk(8'h1D, 13'h0555);
    // Group B write leaves a non-member alone
    group_b_membership <= 6'b000010;
    wr(8'h1C, 13'h1F0F);
    rd_chk(8'h1D, 13'h0555);
    rd_chk(8'h1C, 13'h1F0F);
    // Duty zero never lights, full duty always lights
    wr(8'h1D, 13'h0000);
    repeat (2 * PER) @(posedge clk);
    sample(0);
    check({12'h000, acc_or}, 13'h0000);
    wr(8'h1D, 13'h0FFF);
    repeat (3 * PER) @(posedge clk);
    sample(0);
    check({12'h000, acc_and}, 13'h0001);
    // Interval codes on LED3, set through group A without fade
    group_a_membership <= 6'b001000;
    group_b_membership <= 6'b000000;
    for (int c = 0; c < 8; c++) begin
      wr(8'h1A, {10'h000, c[2:0]});
      wr(8'h1B, 13'h0000);
      repeat (34 * PER) @(posedge clk);
      sample(3);
      check({12'h000, acc_or}, 13'h0000);
      wr(8'h1B, 13'h0FFF);
      wait_lit(3, n);
      check({12'h000, n <= ((1 << ((c > 5) ? 5 : c)) + 1) * PER + 4}, 13'h0001);
    end
    // Untouched LEDs stay dark from reset
    sample(4);
    check({12'h000, acc_or}, 13'h0000);
    sample(5);
    check({12'h000, acc_or}, 13'h0000);
    // Fade toward full duty on LED0 takes many periods, so it is not yet fully on
    wr(8'h1D, 13'h0000);
    repeat (2 * PER) @(posedge clk);
    wr(8'h1D, 13'h1FFF);
    repeat (2 * PER) @(posedge clk);
    sample(0);
    check({12'h000, acc_and}, 13'h0000);
    check({12'h000, acc_or}, 13'h0001);
    tally_and_finish();
  end
endmodule // tb_top
